//--- include/ssrm_params.svh
`ifndef SSRM_PARAMS_SVH
`define SSRM_PARAMS_SVH
// Printed offsets are register indices; byte address is four times the index
`define SSRM_IDX_SYS_FLAGS 8'h10
`define SSRM_IDX_TOUCH_STATUS 8'h31
`define SSRM_IDX_FUSE_ONE 8'hc5
`define SSRM_IDX_FUSE_THREE 8'hc7
`define SSRM_IDX_INIT_PTR 8'hc8
`define SSRM_IDX_EVT_STATUS 8'he0
`define SSRM_IDX_EVT_MASK 8'he1
`define SSRM_IDX_COMM_PTR 8'he2
`define SSRM_PTR_RESET 8'h10
`define SSRM_BIT_OUT_POL 5
`define SSRM_BIT_HALT 4
`define SSRM_BIT_LOW_POWER 3
`define SSRM_BIT_TUNE_BUSY 2
`define SSRM_BIT_NOISE 1
`define SSRM_BIT_FULL_SPEED 0
`define SSRM_BIT_TOUCH 1
`define SSRM_BIT_PROX 0
`define SSRM_EVT_TOUCH 0
`define SSRM_EVT_PROX 1
`define SSRM_EVT_NOISE 2
`define SSRM_EVT_WINDOW 3
`define SSRM_EVT_WIDTH 4
`endif

//--- include/ssrm_pkg.sv
package ssrm_pkg;
	typedef struct packed {
		logic out_active_high;
		logic filter_halted;
		logic low_power_sampling_flag;
		logic auto_tune_busy;
		logic noise_detected;
		logic undebounced_prox;
		logic touch;
		logic prox;
	} ssrm_sense_s;
	typedef logic [7:0] ssrm_byte_t;
endpackage

//--- rtl/ssrm_regs.sv
`timescale 1ns/10ps
`include "ssrm_params.svh"
// Operation
// [RULE1] Bit 5 reports logic output polarity
// [RULE2] Bit 4 high while average filter halted
// [RULE3] Bit 3 selects low-power sample interval; the code only mirrors SENSE.low_power_sampling_flag here and ignores writes
// [RULE4] Bit 2 high while auto-tune runs
// [RULE5] Bit 1 high when noise detected
// [RULE6] Bit 0 high on undebounced proximity full-speed
// [RULE7] Boost mode proximity leaves charge rate unchanged
// [RULE8] Status bit 1 reports touch
// [RULE9] Status bit 0 reports proximity
// [RULE10] Window start loads pointer from default register
// [RULE11] Read at window start returns pointed register
// [RULE12] Fuse bank bytes read-only; third unused
// [RULE13] Undefined status bits zero; read-only writes ignored
module ssrm_regs import ssrm_pkg::*; #(
	parameter logic [7:0] FUSE_ONE_VALUE = 8'h00 // Arbitrary strap value
) (
	input wire logic SYS_CLK, // 25 MHz clock
	input wire logic SRST, // Sync reset, high
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB enable
	input wire logic PWRITE, // APB direction
	input wire logic [11:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error
	input wire ssrm_sense_s SENSE, // Sense core state, same clock
	input wire logic BOOST_POWER_MODE, // Boost-power sampling active
	input wire logic WINDOW_START, // Comm window opens, pulse
	input wire logic WINDOW_READ, // Serial read at pointer, pulse
	output logic [7:0] WINDOW_DATA, // Byte returned to serial side
	output logic [7:0] COMM_PTR, // Active comm pointer
	output logic FULL_SPEED_CHARGE, // Charge rate boost request
	output logic IRQ // Level interrupt
);
	logic [7:0] init_ptr_r;
	logic [7:0] comm_ptr_r;
	logic [7:0] sys_flags_r;
	logic [7:0] status_r;
	logic [`SSRM_EVT_WIDTH-1:0] evt_r;
	logic [`SSRM_EVT_WIDTH-1:0] mask_r;
	logic [`SSRM_EVT_WIDTH-1:0] evt_set;
	logic [7:0] prev_status_r;
	logic noise_prev_r;
	logic [31:0] rdata_nxt;
	logic [7:0] win_nxt;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic [7:0] idx;

	assign access = PSEL && PENABLE;
	assign wr = access && PWRITE;
	assign rd = access && !PWRITE;
	assign idx = PADDR[9:2];
	assign PREADY = 1'b1;
	assign PSLVERR = access && (!mapped || PADDR[11:10] != 2'b00 || PADDR[1:0] != 2'b00);

	// Flags sampled once per cycle so a read sees a coherent byte
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			sys_flags_r <= 8'h00;
			status_r <= 8'h00;
		end else begin
			sys_flags_r <= {2'b00, SENSE.out_active_high, SENSE.filter_halted, // see [RULE1] [RULE2]
				SENSE.low_power_sampling_flag, SENSE.auto_tune_busy, // see [RULE3] [RULE4]
				SENSE.noise_detected, SENSE.undebounced_prox}; // see [RULE5] [RULE6]
			status_r <= {6'h00, SENSE.touch, SENSE.prox}; // see [RULE8] [RULE9] [RULE13]
		end
	end

	// Boost mode already charges at full rate, so the flag alone changes nothing
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			FULL_SPEED_CHARGE <= 1'b0;
		end else begin
			FULL_SPEED_CHARGE <= SENSE.undebounced_prox && !BOOST_POWER_MODE; // see [RULE7]
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			init_ptr_r <= `SSRM_PTR_RESET;
			mask_r <= '0;
		end else if (wr) begin
			if (idx == `SSRM_IDX_INIT_PTR && PADDR[11:10] == 2'b00) begin
				init_ptr_r <= PWDATA[7:0];
			end
			if (idx == `SSRM_IDX_EVT_MASK && PADDR[11:10] == 2'b00) begin
				mask_r <= PWDATA[`SSRM_EVT_WIDTH-1:0];
			end
		end
	end

	// Window start wins; a read does not advance the pointer
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			comm_ptr_r <= `SSRM_PTR_RESET;
		end else if (WINDOW_START) begin
			comm_ptr_r <= init_ptr_r; // see [RULE10]
		end
	end
	assign COMM_PTR = comm_ptr_r;

	function automatic logic [7:0] reg_byte(input logic [7:0] a);
		case (a)
			`SSRM_IDX_SYS_FLAGS: reg_byte = sys_flags_r;
			`SSRM_IDX_TOUCH_STATUS: reg_byte = status_r;
			`SSRM_IDX_FUSE_ONE: reg_byte = FUSE_ONE_VALUE; // see [RULE12]
			`SSRM_IDX_FUSE_THREE: reg_byte = 8'h00; // see [RULE12]
			`SSRM_IDX_INIT_PTR: reg_byte = init_ptr_r;
			default: reg_byte = 8'h00;
		endcase
	endfunction

	// Next pointer seen by a read in the same cycle as window start
	always_comb begin
		win_nxt = reg_byte(WINDOW_START ? init_ptr_r : comm_ptr_r); // see [RULE11]
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			WINDOW_DATA <= 8'h00;
		end else if (WINDOW_READ) begin
			WINDOW_DATA <= win_nxt; // see [RULE11]
		end
	end

	always_comb begin
		mapped = 1'b1;
		rdata_nxt = 32'h0000_0000;
		case (idx)
			`SSRM_IDX_SYS_FLAGS,
			`SSRM_IDX_TOUCH_STATUS,
			`SSRM_IDX_FUSE_ONE,
			`SSRM_IDX_FUSE_THREE,
			`SSRM_IDX_INIT_PTR: rdata_nxt = {24'h00_0000, reg_byte(idx)};
			`SSRM_IDX_EVT_STATUS: rdata_nxt = {28'h000_0000, evt_r};
			`SSRM_IDX_EVT_MASK: rdata_nxt = {28'h000_0000, mask_r};
			`SSRM_IDX_COMM_PTR: rdata_nxt = {24'h00_0000, comm_ptr_r};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= (PADDR[11:10] == 2'b00) ? rdata_nxt : 32'h0000_0000;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			prev_status_r <= 8'h00;
			noise_prev_r <= 1'b0;
		end else begin
			prev_status_r <= status_r;
			noise_prev_r <= sys_flags_r[`SSRM_BIT_NOISE];
		end
	end

	always_comb begin
		evt_set = '0;
		evt_set[`SSRM_EVT_TOUCH] = status_r[`SSRM_BIT_TOUCH] && !prev_status_r[`SSRM_BIT_TOUCH];
		evt_set[`SSRM_EVT_PROX] = status_r[`SSRM_BIT_PROX] && !prev_status_r[`SSRM_BIT_PROX];
		evt_set[`SSRM_EVT_NOISE] = sys_flags_r[`SSRM_BIT_NOISE] && !noise_prev_r;
		evt_set[`SSRM_EVT_WINDOW] = WINDOW_START;
	end

	// Read clears on the access edge; new events in that cycle survive
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			evt_r <= '0;
		end else if (rd && idx == `SSRM_IDX_EVT_STATUS && PADDR[11:10] == 2'b00) begin
			evt_r <= evt_set;
		end else begin
			evt_r <= evt_r | evt_set;
		end
	end

	assign IRQ = |(evt_r & mask_r);

	property flags_track_p;
		@(posedge SYS_CLK) disable iff (SRST)
		sys_flags_r[5:0] == {$past(SENSE.out_active_high), $past(SENSE.filter_halted),
			$past(SENSE.low_power_sampling_flag), $past(SENSE.auto_tune_busy),
			$past(SENSE.noise_detected), $past(SENSE.undebounced_prox)};
	endproperty
	flag_polarity_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		##1 sys_flags_r[`SSRM_BIT_OUT_POL] == $past(SENSE.out_active_high)) // see [RULE1]
		else $error("polarity flag wrong");
	flag_halt_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		##1 sys_flags_r[`SSRM_BIT_HALT] == $past(SENSE.filter_halted)) // see [RULE2]
		else $error("halt flag wrong");
	flag_lowpower_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		##1 sys_flags_r[`SSRM_BIT_LOW_POWER] == $past(SENSE.low_power_sampling_flag)) // see [RULE3]
		else $error("low power flag wrong");
	flag_tune_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		##1 sys_flags_r[`SSRM_BIT_TUNE_BUSY] == $past(SENSE.auto_tune_busy)) // see [RULE4]
		else $error("tune flag wrong");
	flag_noise_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		##1 sys_flags_r[`SSRM_BIT_NOISE] == $past(SENSE.noise_detected)) // see [RULE5]
		else $error("noise flag wrong");
	flags_word_a: assert property (flags_track_p) // see [RULE6]
		else $error("system flags mismatch");
	boost_rate_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		BOOST_POWER_MODE |=> !FULL_SPEED_CHARGE) // see [RULE7]
		else $error("boost charge rate changed");
	status_touch_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		##1 status_r[`SSRM_BIT_TOUCH] == $past(SENSE.touch)) // see [RULE8]
		else $error("touch bit wrong");
	status_prox_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		##1 status_r[`SSRM_BIT_PROX] == $past(SENSE.prox)) // see [RULE9]
		else $error("prox bit wrong");
	sequence win_open_s;
		WINDOW_START && !SRST;
	endsequence
	ptr_load_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		win_open_s |=> comm_ptr_r == $past(init_ptr_r)) // see [RULE10]
		else $error("pointer not loaded");
	win_read_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		WINDOW_START && WINDOW_READ |=> WINDOW_DATA == $past(reg_byte(init_ptr_r))) // see [RULE11]
		else $error("window read wrong byte");
	status_zero_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		status_r[7:2] == 6'h00) // see [RULE13]
		else $error("status upper bits set");

	// Bus side checks; zero wait states, so every access completes at once
	sequence apb_access_s;
		PSEL && PENABLE;
	endsequence
	sequence read_setup_s;
		PSEL && !PENABLE && !PWRITE && PADDR[11:10] == 2'b00;
	endsequence
	ready_high_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		PREADY)
		else $error("ready low");
	slverr_unmapped_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		apb_access_s ##0 !mapped |-> PSLVERR)
		else $error("unmapped access not flagged");
	read_load_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		read_setup_s |=> PRDATA == $past(rdata_nxt))
		else $error("read data not loaded");
	fuse_zero_a: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RULE12]
		read_setup_s ##0 (idx == `SSRM_IDX_FUSE_THREE) |=> PRDATA == 32'h0000_0000)
		else $error("unused fuse byte not zero");
	init_write_a: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RULE10]
		apb_access_s ##0 (PWRITE && idx == `SSRM_IDX_INIT_PTR && PADDR[11:10] == 2'b00)
		|=> init_ptr_r == $past(PWDATA[7:0]))
		else $error("default pointer write lost");
	mask_write_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		apb_access_s ##0 (PWRITE && idx == `SSRM_IDX_EVT_MASK && PADDR[11:10] == 2'b00)
		|=> mask_r == $past(PWDATA[`SSRM_EVT_WIDTH-1:0]))
		else $error("mask write lost");

	// Pointer and serial read side, reserved flag bits and charge request
	ptr_hold_a: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RULE10]
		!WINDOW_START |=> comm_ptr_r == $past(comm_ptr_r))
		else $error("pointer moved without window");
	ptr_reset_a: assert property (@(posedge SYS_CLK) // see [RULE10]
		SRST |=> comm_ptr_r == `SSRM_PTR_RESET && init_ptr_r == `SSRM_PTR_RESET)
		else $error("pointer reset value wrong");
	win_data_a: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RULE11]
		WINDOW_READ && !WINDOW_START |=> WINDOW_DATA == $past(reg_byte(comm_ptr_r)))
		else $error("window byte wrong");
	win_hold_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		!WINDOW_READ |=> $stable(WINDOW_DATA))
		else $error("window byte changed");
	flags_upper_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		sys_flags_r[7:6] == 2'b00)
		else $error("reserved flags set");
	charge_rate_a: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RULE6]
		SENSE.undebounced_prox && !BOOST_POWER_MODE |=> FULL_SPEED_CHARGE)
		else $error("full speed not requested");

	// Event capture: a rise of touch, prox or noise, and every window start, must reach the sticky bits
	touch_event_a: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RULE8]
		$rose(status_r[`SSRM_BIT_TOUCH]) |=> evt_r[`SSRM_EVT_TOUCH])
		else $error("touch event missed");
	prox_event_a: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RULE9]
		$rose(status_r[`SSRM_BIT_PROX]) |=> evt_r[`SSRM_EVT_PROX])
		else $error("prox event missed");
	noise_event_a: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RULE5]
		$rose(sys_flags_r[`SSRM_BIT_NOISE]) |=> evt_r[`SSRM_EVT_NOISE])
		else $error("noise event missed");
	window_event_a: assert property (@(posedge SYS_CLK) disable iff (SRST) // see [RULE10]
		WINDOW_START |=> evt_r[`SSRM_EVT_WINDOW])
		else $error("window event missed");
	evt_clear_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
		rd && idx == `SSRM_IDX_EVT_STATUS && PADDR[11:10] == 2'b00 |=> evt_r == $past(evt_set))
		else $error("event status not cleared");
	for (genvar gi = 0; gi < `SSRM_EVT_WIDTH; gi++) begin : g_evt_chk
		evt_keep_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
			evt_r[gi] && !(rd && idx == `SSRM_IDX_EVT_STATUS) |=> evt_r[gi])
			else $error("event bit lost");
		evt_catch_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
			evt_set[gi] |=> evt_r[gi])
			else $error("event bit missed");
	end
endmodule

//--- verification/ssrm_host_model.sv
`timescale 1ns/10ps
module ssrm_host_model (
	input wire logic SYS_CLK, // Device clock
	input wire logic [7:0] WINDOW_DATA, // Byte from device
	output logic WINDOW_START, // Window opens
	output logic WINDOW_READ // Read at pointer
);
	initial begin
		WINDOW_START = 1'b0;
		WINDOW_READ = 1'b0;
	end
	// Read in the opening cycle, no address phase
	task automatic open_read(output logic [7:0] data);
		@(posedge SYS_CLK);
		WINDOW_START <= 1'b1;
		WINDOW_READ <= 1'b1;
		@(posedge SYS_CLK);
		WINDOW_START <= 1'b0;
		WINDOW_READ <= 1'b0;
		@(posedge SYS_CLK);
		data = WINDOW_DATA;
	endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/10ps
`include "ssrm_params.svh"
module testbench import ssrm_pkg::*;;
	logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, boost;
	logic win_start, win_read, fsc, irq, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [7:0] win_data, comm_ptr, b;
	ssrm_sense_s sense;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	ssrm_regs u_dut (.SYS_CLK(sys_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SENSE(sense), .BOOST_POWER_MODE(boost), .WINDOW_START(win_start),
		.WINDOW_READ(win_read), .WINDOW_DATA(win_data), .COMM_PTR(comm_ptr),
		.FULL_SPEED_CHARGE(fsc), .IRQ(irq));
	ssrm_host_model u_host (.SYS_CLK(sys_clk), .WINDOW_DATA(win_data),
		.WINDOW_START(win_start), .WINDOW_READ(win_read));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic complete_run();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Ceiling well above the roughly 150 cycles the sequence needs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			$display("[ERR] %0t timeout", $time);
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got 0x%0h exp 0x%0h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rdat, exp);
	endtask
	// Flags lag the sense core by a cycle, so leave margin
	task automatic set_in(input logic [7:0] s, input logic bp);
		@(posedge sys_clk);
		sense <= ssrm_sense_s'(s);
		boost <= bp;
		repeat (3) @(posedge sys_clk);
	endtask
	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sense = '0;
		boost = 1'b0;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		rd_chk(`SSRM_IDX_INIT_PTR, 32'h10);
		chk({24'h0, comm_ptr}, 32'h10);
		chk({31'h0, pready}, 32'h1);
		for (int i = 0; i < 6; i++) begin
			set_in(8'h04 << i, 1'b0);
			rd_chk(`SSRM_IDX_SYS_FLAGS, 32'h1 << i);
		end
		set_in(8'h04, 1'b1);
		@(negedge sys_clk);
		chk({31'h0, fsc}, 32'h0);
		rd_chk(`SSRM_IDX_SYS_FLAGS, 32'h1);
		set_in(8'h04, 1'b0);
		@(negedge sys_clk);
		chk({31'h0, fsc}, 32'h1);
		for (int j = 0; j < 4; j++) begin
			set_in(8'hfc | j, 1'b0);
			rd_chk(`SSRM_IDX_TOUCH_STATUS, j);
		end
		apb(1'b1, `SSRM_IDX_TOUCH_STATUS, 32'hff);
		rd_chk(`SSRM_IDX_TOUCH_STATUS, 32'h3);
		apb(1'b1, `SSRM_IDX_FUSE_THREE, 32'hff);
		rd_chk(`SSRM_IDX_FUSE_THREE, 32'h0);
		apb(1'b1, `SSRM_IDX_FUSE_ONE, 32'hff);
		rd_chk(`SSRM_IDX_FUSE_ONE, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk({rerr, rdat[30:0]}, 32'h80000000);
		set_in(8'h00, 1'b0);
		apb(1'b1, `SSRM_IDX_EVT_MASK, 32'h0);
		apb(1'b0, `SSRM_IDX_EVT_STATUS, 32'h0);
		set_in(8'h02, 1'b0);
		@(negedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `SSRM_IDX_EVT_MASK, 32'h1);
		@(negedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		rd_chk(`SSRM_IDX_EVT_STATUS, 32'h1);
		@(negedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `SSRM_IDX_INIT_PTR, 32'h31);
		rd_chk(`SSRM_IDX_INIT_PTR, 32'h31);
		u_host.open_read(b);
		chk({24'h0, b}, 32'h2);
		chk({24'h0, comm_ptr}, 32'h31);
		rd_chk(`SSRM_IDX_COMM_PTR, 32'h31);
		rd_chk(`SSRM_IDX_EVT_STATUS, 32'h8);
		complete_run();
	end
endmodule
